// *** src/cwf_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the wake filter.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CWF_CFG_SVH
`define CWF_CFG_SVH

`define CWF_ADDR_W 8
`define CWF_OFS_CTRL 8'h00
`define CWF_OFS_BITRATE 8'h04
`define CWF_OFS_TIMEOUT 8'h08
`define CWF_OFS_ID_VAL 8'h0c
`define CWF_OFS_ID_MSK 8'h10
`define CWF_OFS_DVAL_LO 8'h14
`define CWF_OFS_DVAL_HI 8'h18
`define CWF_OFS_DMSK_LO 8'h1c
`define CWF_OFS_DMSK_HI 8'h20
`define CWF_OFS_STATUS 8'h24
`define CWF_OFS_ACK 8'h28

`define CWF_CTRL_NORMAL 0
`define CWF_CTRL_MODE_LO 1
`define CWF_CTRL_MODE_HI 2
`define CWF_CTRL_ID_EXT 3

`define CWF_ST_RUN 0
`define CWF_ST_INACTIVE 1
`define CWF_ST_ALERT 2
`define CWF_ST_IGN 3
`define CWF_ST_CNT_LO 16

`define CWF_STD_ID_W 11
`define CWF_EXT_ID_W 29

`define CWF_RST_BITRATE 16'h0028
`define CWF_RST_TIMEOUT 16'h03e8

`define CWF_CLK_HZ 20000000
`define CWF_TICK_MS 1
`define CWF_TICK_CYCLES ((`CWF_CLK_HZ / 1000) * `CWF_TICK_MS)

`endif

// *** src/cwf_pkg.sv ***
// Types shared by the wake filter modules.
// Assumes the configuration header is on the include path.
`include "cwf_cfg.svh"

package cwf_pkg;

   typedef enum logic [1:0] {
      CWF_MODE_DIS = 2'h0,
      CWF_MODE_EN = 2'h1,
      CWF_MODE_LOSSLESS = 2'h2,
      CWF_MODE_KEEP = 2'h3
   } cwf_mode_t;

   typedef enum logic [1:0] {
      CWF_SLEEP = 2'h1,
      CWF_RUN = 2'h2
   } cwf_fsm_t;

   typedef struct packed {
      cwf_fsm_t fsm;
      logic silent;
      cwf_mode_t mode;
      logic id_ext;
      logic [15:0] bitrate;
      logic [15:0] timeout;
      logic [`CWF_EXT_ID_W-1:0] id_val;
      logic [`CWF_EXT_ID_W-1:0] id_msk;
      logic [63:0] dat_val;
      logic [63:0] dat_msk;
      logic [15:0] tick_cnt;
      logic [15:0] tmo_cnt;
      logic alert;
      logic log_pulse;
      logic frame_wake;
      logic run;
      logic rx_low;
      logic [31:0] rdata;
   } cwf_state_t;

endpackage

// *** src/cwf_sync.sv ***
// Two flip-flop synchroniser for one level arriving from a pin.
// Assumes the level changes slowly compared with the system clock.
module cwf_sync (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Level in and out
   input wire logic async_i,
   output logic sync_o
);

   typedef struct packed {
      logic meta;
      logic stable;
   } cwf_sync_t;

   cwf_sync_t s_r;
   cwf_sync_t s_nxt;

   always_comb begin
      s_nxt.meta = async_i;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sync_o = s_r.stable;

endmodule

// *** src/cwf_match.sv ***
// Masked compare of an observed word against a programmed value.
// Assumes all inputs are from the same clock domain; the result is combinational.
module cwf_match #(
   parameter int W = 64
) (
   // Programmed value and mask
   input wire logic [W-1:0] val_i,
   input wire logic [W-1:0] msk_i,
   // Observed word and result
   input wire logic [W-1:0] obs_i,
   output logic hit_o
);

   // Only positions with a mask one take part; an all-zero mask always hits.
   assign hit_o = ~|((obs_i ^ val_i) & msk_i); // [RULE_09] [RULE_14] [RULE_15] [RULE_17]

endmodule

// *** src/can_wake_filter.sv ***
// Wake-up filter and channel control for one CAN channel of a data logger.
// Assumes a same-clock CAN controller that presents each received frame as a
// one-cycle strobe, and an ignition level that arrives straight from a pin.
//
// Functional notes
// [RULE_01] Normal setting on lets the channel drive the bus; off keeps it silent.
// [RULE_02] Channel runs at the programmed bit rate shared by all bus nodes.
// [RULE_03] No qualifying frame for the timeout marks the wake source inactive.
// [RULE_04] Timeout makes a log entry and a pending alert until acknowledged.
// [RULE_05] Disabled mode never starts the logger; receiver held in low power.
// [RULE_06] Enabled mode starts on a frame; receiver stays in standby asleep.
// [RULE_07] Lossless mode starts on a frame with the receiver kept powered.
// [RULE_08] Keep-awake starts on ignition; stops when ignition and frames are gone.
// [RULE_09] Identifier bits with a mask one must equal the programmed identifier.
// [RULE_10] Standard frames compare an 11-bit identifier, bits 0 to 10.
// [RULE_11] Identifier value and mask are standard or extended; format must agree.
// [RULE_12] A zero identifier mask accepts every received frame.
// [RULE_13] The payload filter spans all 64 payload bits.
// [RULE_14] Payload mask one includes a position, zero excludes it.
// [RULE_15] Every masked payload bit must equal the programmed payload value.
// [RULE_16] A wake needs both identifier and payload filters to pass.
// [RULE_17] A zero payload mask accepts any payload.
// [RULE_18] The wake frame keeps the logger running; its absence stops it.
// [RULE_19] Timer restarts on each qualifying frame, expires after the full timeout.
// [RULE_20] Only one nominal bit rate; no flexible data rate.
//
// Added by the designer: the address map and strobed register access.
`include "cwf_cfg.svh"

module can_wake_filter
   import cwf_pkg::*;
#(
   parameter int TICK_CYCLES = `CWF_TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Register port
   input wire logic [`CWF_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Received frames from the controller
   input wire logic rx_valid_i,
   input wire logic rx_ext_i,
   input wire logic [`CWF_EXT_ID_W-1:0] rx_id_i,
   input wire logic [63:0] rx_data_i,
   // Ignition pin
   input wire logic ignition_i,
   // Controller and transceiver control
   output logic silent_o,
   output logic [15:0] bit_div_o,
   output logic rx_low_power_o,
   // Logger control and events
   output logic logger_run_o,
   output logic any_wake_source_o,
   output logic bus_frame_wake_o,
   output logic log_entry_o,
   output logic alert_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State and filters

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
   localparam logic [`CWF_EXT_ID_W-1:0] STD_ID_MASK = `CWF_EXT_ID_W'(12'h7ff);

   cwf_state_t s_r;
   cwf_state_t s_nxt;
   logic ign_s;
   logic id_hit;
   logic dat_hit;
   logic fmt_ok;
   logic id_ok;
   logic qual;
   logic expire;
   logic inactive;
   logic wake_mode;
   logic [`CWF_EXT_ID_W-1:0] id_msk_eff;

   cwf_sync u_ign_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i(ignition_i),
      .sync_o(ign_s)
   );

   // Standard format only looks at the low 11 identifier bits.
   assign id_msk_eff = s_r.id_ext ? s_r.id_msk : (s_r.id_msk & STD_ID_MASK); // [RULE_10]

   cwf_match #(
      .W(`CWF_EXT_ID_W)
   ) u_id_match (
      .val_i(s_r.id_val),
      .msk_i(id_msk_eff),
      .obs_i(rx_id_i),
      .hit_o(id_hit)
   );

   cwf_match #(
      .W(64)
   ) u_dat_match (
      .val_i(s_r.dat_val),
      .msk_i(s_r.dat_msk),
      .obs_i(rx_data_i), // [RULE_13]
      .hit_o(dat_hit)
   );

   assign fmt_ok = (rx_ext_i == s_r.id_ext); // [RULE_11]
   assign id_ok = (id_msk_eff == '0) | (id_hit & fmt_ok); // [RULE_12]
   assign qual = rx_valid_i & id_ok & dat_hit; // [RULE_16]
   assign wake_mode = (s_r.mode != CWF_MODE_DIS);
   assign inactive = (s_r.tmo_cnt == 16'h0000); // [RULE_03]
   assign expire = (s_r.fsm == CWF_RUN) & (s_r.tmo_cnt == 16'h0001)
                 & (s_r.tick_cnt == TICK_LAST) & ~qual;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_nxt = s_r;
      s_nxt.log_pulse = 1'b0;
      s_nxt.frame_wake = 1'b0;
      s_nxt.rdata = 32'h0000_0000;

      // Register writes.
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `CWF_OFS_CTRL: begin
               s_nxt.silent = ~reg_wdata_i[`CWF_CTRL_NORMAL];
               s_nxt.mode = cwf_mode_t'(reg_wdata_i[`CWF_CTRL_MODE_HI:`CWF_CTRL_MODE_LO]);
               s_nxt.id_ext = reg_wdata_i[`CWF_CTRL_ID_EXT];
            end
            `CWF_OFS_BITRATE: s_nxt.bitrate = reg_wdata_i[15:0]; // [RULE_20]
            `CWF_OFS_TIMEOUT: s_nxt.timeout = reg_wdata_i[15:0];
            `CWF_OFS_ID_VAL: s_nxt.id_val = reg_wdata_i[`CWF_EXT_ID_W-1:0];
            `CWF_OFS_ID_MSK: s_nxt.id_msk = reg_wdata_i[`CWF_EXT_ID_W-1:0];
            `CWF_OFS_DVAL_LO: s_nxt.dat_val[31:0] = reg_wdata_i;
            `CWF_OFS_DVAL_HI: s_nxt.dat_val[63:32] = reg_wdata_i;
            `CWF_OFS_DMSK_LO: s_nxt.dat_msk[31:0] = reg_wdata_i;
            `CWF_OFS_DMSK_HI: s_nxt.dat_msk[63:32] = reg_wdata_i;
            `CWF_OFS_ACK: begin
               if (reg_wdata_i[0]) begin
                  s_nxt.alert = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Register reads, answered in the following cycle only.
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `CWF_OFS_CTRL: s_nxt.rdata = {28'h0, s_r.id_ext, s_r.mode, ~s_r.silent};
            `CWF_OFS_BITRATE: s_nxt.rdata = {16'h0000, s_r.bitrate};
            `CWF_OFS_TIMEOUT: s_nxt.rdata = {16'h0000, s_r.timeout};
            `CWF_OFS_ID_VAL: s_nxt.rdata = {3'h0, s_r.id_val};
            `CWF_OFS_ID_MSK: s_nxt.rdata = {3'h0, s_r.id_msk};
            `CWF_OFS_DVAL_LO: s_nxt.rdata = s_r.dat_val[31:0];
            `CWF_OFS_DVAL_HI: s_nxt.rdata = s_r.dat_val[63:32];
            `CWF_OFS_DMSK_LO: s_nxt.rdata = s_r.dat_msk[31:0];
            `CWF_OFS_DMSK_HI: s_nxt.rdata = s_r.dat_msk[63:32];
            `CWF_OFS_STATUS: begin
               s_nxt.rdata[`CWF_ST_RUN] = s_r.run;
               s_nxt.rdata[`CWF_ST_INACTIVE] = inactive;
               s_nxt.rdata[`CWF_ST_ALERT] = s_r.alert;
               s_nxt.rdata[`CWF_ST_IGN] = ign_s;
               s_nxt.rdata[31:`CWF_ST_CNT_LO] = s_r.tmo_cnt;
            end
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end

      // Inactivity timer in millisecond ticks.
      if (qual && wake_mode) begin
         s_nxt.tick_cnt = 16'h0000; // [RULE_19]
         s_nxt.tmo_cnt = s_r.timeout;
         s_nxt.frame_wake = 1'b1;
      end else if (!inactive) begin
         if (s_r.tick_cnt == TICK_LAST) begin
            s_nxt.tick_cnt = 16'h0000;
            s_nxt.tmo_cnt = s_r.tmo_cnt - 16'h0001;
         end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
         end
      end

      // Timeout event; a same-cycle acknowledge loses against it.
      if (expire && wake_mode) begin
         s_nxt.log_pulse = 1'b1; // [RULE_04]
         s_nxt.alert = 1'b1;
      end

      // Logger run control.
      unique case (s_r.fsm)
         CWF_SLEEP: begin
            if ((s_r.mode == CWF_MODE_EN || s_r.mode == CWF_MODE_LOSSLESS) && qual) begin
               s_nxt.fsm = CWF_RUN; // [RULE_06] [RULE_07]
            end else if (s_r.mode == CWF_MODE_KEEP && (ign_s || qual)) begin
               s_nxt.fsm = CWF_RUN; // [RULE_08]
            end
         end
         CWF_RUN: begin
            if (s_r.mode == CWF_MODE_DIS) begin
               s_nxt.fsm = CWF_SLEEP; // [RULE_05]
            end else if (s_r.mode == CWF_MODE_KEEP) begin
               if (!ign_s && (inactive || expire) && !qual) begin
                  s_nxt.fsm = CWF_SLEEP; // [RULE_08]
               end
            end else if (expire) begin
               s_nxt.fsm = CWF_SLEEP; // [RULE_18]
            end
         end
         default: s_nxt.fsm = CWF_SLEEP;
      endcase

      s_nxt.run = (s_nxt.fsm == CWF_RUN);
      // Receiver power: off when disabled, standby while asleep in basic mode.
      unique case (s_nxt.mode)
         CWF_MODE_DIS: s_nxt.rx_low = 1'b1; // [RULE_05]
         CWF_MODE_EN: s_nxt.rx_low = (s_nxt.fsm == CWF_SLEEP); // [RULE_06]
         CWF_MODE_LOSSLESS: s_nxt.rx_low = 1'b0; // [RULE_07]
         CWF_MODE_KEEP: s_nxt.rx_low = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.fsm <= CWF_SLEEP;
         s_r.mode <= CWF_MODE_DIS;
         s_r.bitrate <= `CWF_RST_BITRATE;
         s_r.timeout <= `CWF_RST_TIMEOUT;
         s_r.rx_low <= 1'b1;
         s_r.silent <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata_o = s_r.rdata;
   assign silent_o = s_r.silent; // [RULE_01]
   assign bit_div_o = s_r.bitrate; // [RULE_02]
   assign rx_low_power_o = s_r.rx_low;
   assign logger_run_o = s_r.run;
   assign any_wake_source_o = s_r.run;
   assign bus_frame_wake_o = s_r.frame_wake;
   assign log_entry_o = s_r.log_pulse;
   assign alert_o = s_r.alert;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   sequence s_ctrl_wr;
      reg_wr_i && reg_addr_i == `CWF_OFS_CTRL;
   endsequence

   sequence s_qual_frame;
      qual && wake_mode;
   endsequence

   sequence s_ack;
      reg_wr_i && reg_addr_i == `CWF_OFS_ACK && reg_wdata_i[0];
   endsequence

   property p_silent;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_ctrl_wr |=> (silent_o == !$past(reg_wdata_i[0]));
   endproperty
   a_silent: assert property (p_silent) else $error("silent output wrong"); // [RULE_01]

   property p_disabled;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_r.mode == CWF_MODE_DIS && !(reg_wr_i && reg_addr_i == `CWF_OFS_CTRL)
         |=> !logger_run_o && rx_low_power_o;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled mode ran"); // [RULE_05]

   property p_frame_start;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_qual_frame ##0 (s_r.mode != CWF_MODE_KEEP) |=> bus_frame_wake_o && logger_run_o;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame did not wake"); // [RULE_06]

   property p_lossless;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_r.mode == CWF_MODE_LOSSLESS && !reg_wr_i |=> !rx_low_power_o;
   endproperty
   a_lossless: assert property (p_lossless) else $error("receiver off"); // [RULE_07]

   property p_keep;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_r.mode == CWF_MODE_KEEP && ign_s && !reg_wr_i |=> logger_run_o;
   endproperty
   a_keep: assert property (p_keep) else $error("ignition did not keep awake"); // [RULE_08]

   property p_expire;
      @(posedge clk_sys_i) disable iff (rst_i)
      expire && wake_mode |=> log_entry_o && alert_o ##1 !log_entry_o;
   endproperty
   a_expire: assert property (p_expire) else $error("timeout not reported"); // [RULE_04]

   property p_alert_hold;
      @(posedge clk_sys_i) disable iff (rst_i)
      alert_o && !(reg_wr_i && reg_addr_i == `CWF_OFS_ACK && reg_wdata_i[0]) |=> alert_o;
   endproperty
   a_alert_hold: assert property (p_alert_hold) else $error("alert dropped"); // [RULE_04]

   property p_ack_clear;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_ack ##0 !(expire && wake_mode) |=> !alert_o;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("alert not cleared"); // [RULE_04]

   property p_restart;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_qual_frame |=> s_r.tmo_cnt == $past(s_r.timeout) && s_r.tick_cnt == 16'h0000;
   endproperty
   a_restart: assert property (p_restart) else $error("timer not restarted"); // [RULE_19]

   property p_mask_zero;
      @(posedge clk_sys_i) disable iff (rst_i)
      rx_valid_i && id_msk_eff == '0 && s_r.dat_msk == 64'h0 |-> qual;
   endproperty
   a_mask_zero: assert property (p_mask_zero) else $error("zero masks refused"); // [RULE_12]

   property p_both;
      @(posedge clk_sys_i) disable iff (rst_i)
      bus_frame_wake_o |-> $past(dat_hit) && $past(id_ok);
   endproperty
   a_both: assert property (p_both) else $error("wake without both filters"); // [RULE_16]

endmodule

// *** tb/cwf_can_node.sv ***
// Model of the other nodes on the bus, seen through a same-clock controller.
// Assumes the bench asks for one frame at a time with a one-cycle send strobe.
`include "cwf_cfg.svh"

module cwf_can_node
   import cwf_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Frame request from the bench
   input wire logic send_i,
   input wire logic ext_i,
   input wire logic [`CWF_EXT_ID_W-1:0] id_i,
   input wire logic [63:0] data_i,
   // Frame towards the filter
   output logic rx_valid_o,
   output logic rx_ext_o,
   output logic [`CWF_EXT_ID_W-1:0] rx_id_o,
   output logic [63:0] rx_data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic valid;
      logic ext;
      logic [`CWF_EXT_ID_W-1:0] id;
      logic [63:0] data;
   } cwf_node_t;

   cwf_node_t st_r;
   cwf_node_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Classic frames only, all nodes at the one nominal rate.
   // Outside a frame the identifier and payload toggle so stale values never look valid.
   always_comb begin
      st_nxt = st_r;
      st_nxt.valid = send_i;
      if (send_i) begin
         st_nxt.ext = ext_i;
         st_nxt.id = id_i;
         st_nxt.data = data_i;
      end else begin
         st_nxt.id = ~st_r.id;
         st_nxt.data = ~st_r.data;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rx_valid_o = st_r.valid;
   assign rx_ext_o = st_r.ext;
   assign rx_id_o = st_r.id;
   assign rx_data_o = st_r.data;
endmodule

// *** tb/can_wake_filter_tb.sv ***
// Self-checking bench for the wake filter with a short timer tick.
// Assumes the node model feeds frames and the bench owns the register port.
`include "cwf_cfg.svh"

module can_wake_filter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cwf_pkg::*;

   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [`CWF_ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] rdata;
   logic send = 1'b0;
   logic ext = 1'b0;
   logic [`CWF_EXT_ID_W-1:0] id = '0;
   logic [63:0] data = '0;
   logic ignition = 1'b0;
   logic rx_valid, rx_ext, silent, low_pw, run, any_src, fwake, log_ent, alert;
   logic [`CWF_EXT_ID_W-1:0] rx_id;
   logic [63:0] rx_data;
   logic [15:0] bit_div;
   logic [31:0] rd_v;
   int n_mismatch = 0;
   int comparisons = 0;

   always #25 clk_sys_i = ~clk_sys_i;

   cwf_can_node node (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .send_i(send), .ext_i(ext),
      .id_i(id), .data_i(data), .rx_valid_o(rx_valid), .rx_ext_o(rx_ext),
      .rx_id_o(rx_id), .rx_data_o(rx_data));

   can_wake_filter #(.TICK_CYCLES(4)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .rx_valid_i(rx_valid), .rx_ext_i(rx_ext),
      .rx_id_i(rx_id), .rx_data_i(rx_data), .ignition_i(ignition), .silent_o(silent),
      .bit_div_o(bit_div), .rx_low_power_o(low_pw), .logger_run_o(run),
      .any_wake_source_o(any_src), .bus_frame_wake_o(fwake), .log_entry_o(log_ent),
      .alert_o(alert));

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd <= 1'b0;
      #1;
      rd_v = rdata;
   endtask

   task automatic frame(input logic e, input logic [28:0] i, input logic [63:0] d);
      @(posedge clk_sys_i);
      send <= 1'b1;
      ext <= e;
      id <= i;
      data <= d;
      @(posedge clk_sys_i);
      send <= 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask

   // Expects expiry exactly TIMEOUT(2) * 4 cycles after the last reload.
   task automatic expire_chk();
      repeat (7) @(posedge clk_sys_i);
      #1;
      chk("run_before_expiry", run, 1);
      chk("log_before_expiry", log_ent, 0);
      @(posedge clk_sys_i);
      #1;
      chk("log_entry", log_ent, 1);
      chk("alert", alert, 1);
      chk("run_stop", run, 0);
      chk("wake_src", any_src, 0);
      @(posedge clk_sys_i);
      #1;
      chk("log_pulse_end", log_ent, 0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   logic [28:0] t_id [5] = '{29'h119, 29'h115, 29'h115, 29'h115, 29'h414};
   logic t_ext [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   logic [63:0] t_dat [5] = '{64'h1_00000011, 64'h1_0000001c, 64'h1_00000011,
      64'h0_00000011, 64'h1_000000fb};

   initial begin
      #100us;
      n_mismatch++;
      conclude();
   end

   initial begin
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1;
      chk("silent_rst", silent, 1);
      chk("bitdiv_rst", bit_div, 16'h0028);
      chk("lowpw_rst", low_pw, 1);
      rd(`CWF_OFS_STATUS);
      chk("status_rst", rd_v, 32'h0000_0002);
      rd(8'h30);
      chk("unmapped", rd_v, 32'h0);
      wr(`CWF_OFS_BITRATE, 32'h0000_01f4);
      chk("bitdiv", bit_div, 16'h01f4);
      wr(`CWF_OFS_ID_VAL, 32'h16);
      wr(`CWF_OFS_ID_MSK, 32'h1c);
      wr(`CWF_OFS_DVAL_LO, 32'h10);
      wr(`CWF_OFS_DMSK_LO, 32'h14);
      wr(`CWF_OFS_DVAL_HI, 32'h1);
      wr(`CWF_OFS_DMSK_HI, 32'h1);
      wr(`CWF_OFS_TIMEOUT, 32'h2);
      frame(0, 29'h115, 64'h1_00000011);
      chk("dis_wake", fwake, 0);
      chk("dis_run", run, 0);
      wr(`CWF_OFS_CTRL, 32'h3);
      chk("silent_off", silent, 0);
      chk("en_lowpw", low_pw, 1);
      rd(`CWF_OFS_CTRL);
      chk("ctrl_rd", rd_v, 32'h0000_0003);
      for (int k = 0; k < 5; k++) begin
         frame(t_ext[k], t_id[k], t_dat[k]);
         chk("wake", fwake, (k == 4));
      end
      chk("en_run", run, 1);
      chk("en_src", any_src, 1);
      chk("en_lowpw_run", low_pw, 0);
      expire_chk();
      rd(`CWF_OFS_STATUS);
      chk("status_alert", rd_v, 32'h0000_0006);
      wr(`CWF_OFS_ACK, 32'h1);
      chk("alert_ack", alert, 0);
      frame(0, 29'h115, 64'h1_00000011);
      repeat (5) @(posedge clk_sys_i);
      frame(0, 29'h115, 64'h1_00000011);
      expire_chk();
      wr(`CWF_OFS_ACK, 32'h1);
      wr(`CWF_OFS_ID_MSK, 32'h0);
      wr(`CWF_OFS_DMSK_LO, 32'h0);
      wr(`CWF_OFS_DMSK_HI, 32'h0);
      wr(`CWF_OFS_CTRL, 32'h5);
      chk("ll_lowpw", low_pw, 0);
      frame(1, 29'h1abcdef, 64'h5a5a_0f0f_1234_8765);
      chk("zero_msk_wake", fwake, 1);
      expire_chk();
      wr(`CWF_OFS_ACK, 32'h1);
      wr(`CWF_OFS_CTRL, 32'h7);
      @(posedge clk_sys_i);
      ignition <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk("keep_run", run, 1);
      rd(`CWF_OFS_STATUS);
      chk("status_keep", rd_v, 32'h0000_000b);
      @(posedge clk_sys_i);
      ignition <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #1;
      chk("keep_stop", run, 0);
      conclude();
   end
endmodule
